//--- dispatch_checker.sv
// Concurrent checks on the dispatcher's ports
// Bound onto the dispatcher from the testbench top
`timescale 1ns/1ps
`default_nettype none
module dispatch_checker #(
   parameter int TRY_CYC = 10
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pslverr,
   // Network stack
   input wire logic [15:0] session_port,
   input wire logic session_open,
   input wire logic session_accept,
   input wire logic dhcp_req,
   input wire logic bootp_req,
   input wire logic lease_ok,
   input wire logic lease_fail,
   input wire logic net_error,
   input wire logic net_ready,
   // Dispatch
   input wire logic [5:0] relay_sel,
   input wire logic self_sel,
   input wire logic req_valid
);
   localparam int TRY_LIM = TRY_CYC + 3;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   AST_PORT: assert property (session_accept == (net_ready && session_open && session_port == 16'h01F6))
      else $error("session accept wrong");
   AST_ONE_TRY: assert property (!(dhcp_req && bootp_req))
      else $error("both lease requests high");
   AST_DHCP_OK: assert property (dhcp_req && lease_ok |=> net_ready && !dhcp_req)
      else $error("dhcp lease not taken");
   AST_BOOTP_OK: assert property (bootp_req && lease_ok |=> net_ready && !bootp_req)
      else $error("bootp lease not taken");
   AST_DHCP_FAIL: assert property (dhcp_req && lease_fail |-> ##[1:2] (net_error || bootp_req))
      else $error("dhcp failure not handled");
   AST_BOOTP_FAIL: assert property (bootp_req && lease_fail |-> ##[1:3] (net_error || net_ready))
      else $error("bootp failure not handled");
   AST_TRY_BOUND: assert property ($rose(dhcp_req) |-> ##[1:TRY_LIM] !dhcp_req)
      else $error("dhcp attempt never ends");
   AST_SEL: assert property (req_valid |-> (self_sel ^ (relay_sel != 6'h00)))
      else $error("accepted request without one target");
   AST_RELAY_MAX: assert property (relay_sel <= 6'h20)
      else $error("relay select above 32");
   AST_STATE: assert property (!(net_ready && net_error))
      else $error("ready and error together");
   AST_SLVERR: assert property (pslverr |-> psel && penable)
      else $error("slave error outside access");
   cover property (net_ready && session_accept);
   cover property (req_valid && self_sel);
   cover property ($rose(net_error));
endmodule // dispatch_checker
`default_nettype wire

//--- dispatch_pkg.sv
// Constants for the request dispatcher: register offsets, network defaults, function codes
// Assumes an APB master on a 40 MHz pclk
// Functional notes
// - Sessions accepted on TCP port 502 only
// - Zero fixed settings use factory defaults
// - Default host is 192.168.1.<MAC low byte>
// - Defaults: mask 255.255.255.0, gateway 192.168.1.254
// - Mode selects DHCP, BOOTP, fixed or fallback
// - DHCP mode reports error on failure
// - BOOTP mode reports error on failure
// - Fallback tries DHCP, BOOTP, then fixed; never errors
// - Fixed mode default; zero fields take defaults
// - Button over ten seconds, restart restores defaults
// - Accept read holding and input registers
// - Accept single and multiple register writes
// - Accept device identification code 0x2B
// - Basic and regular identification, conformity 0x82
// - Unit 255 handled by the controller
// - Units 1 to 32 routed to relays
// - Reads ask 1..125 registers, two bytes each
// - Fixed address split in two 16-bit halves
package dispatch_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [11:0] OFS_CTRL = 12'h0_000;
   localparam logic [11:0] OFS_STATUS = 12'h0_004;
   localparam logic [11:0] OFS_IP_HI = 12'h0_008;
   localparam logic [11:0] OFS_IP_LO = 12'h0_00C;
   localparam logic [11:0] OFS_MASK = 12'h0_010;
   localparam logic [11:0] OFS_GW = 12'h0_014;
   localparam logic [11:0] OFS_REQ = 12'h0_018;
   localparam logic [11:0] OFS_RESP = 12'h0_01C;
   localparam logic [11:0] OFS_ACT_IP = 12'h0_020;
   localparam logic [11:0] OFS_ACT_MASK = 12'h0_024;
   localparam logic [11:0] OFS_ACT_GW = 12'h0_028;
   localparam logic [11:0] OFS_MAC = 12'h0_02C;
   localparam logic [11:0] OFS_RELAYS = 12'h0_030;
   // ------------------------------------------------------------
   // Network defaults
   // ------------------------------------------------------------
   localparam logic [15:0] TCP_PORT = 16'h0_1F6;
   localparam logic [23:0] DEF_NET = 24'hC0_A801;
   localparam logic [31:0] DEF_MASK = 32'hFFFF_FF00;
   localparam logic [31:0] DEF_GW = 32'hC0A8_01FE;
   localparam logic [15:0] ZERO16 = 16'h0_000;
   localparam logic [47:0] MAC_DEFAULT = 48'h0000_0000_0001; // Arbitrary value
   localparam logic [1:0] MODE_RESET = 2'h2;
   // ------------------------------------------------------------
   // Function codes and limits
   // ------------------------------------------------------------
   localparam logic [7:0] FC_RD_HOLD = 8'h03;
   localparam logic [7:0] FC_RD_INPUT = 8'h04;
   localparam logic [7:0] FC_WR_SINGLE = 8'h06;
   localparam logic [7:0] FC_WR_MULTI = 8'h10;
   localparam logic [7:0] FC_DEV_ID = 8'h2B;
   localparam logic [7:0] CONFORMITY = 8'h82;
   localparam logic [7:0] EXC_BIT = 8'h80;
   localparam logic [7:0] EXC_ILLEGAL_FC = 8'h01;
   localparam logic [7:0] EXC_ILLEGAL_VAL = 8'h03;
   localparam logic [7:0] EXC_GW_PATH = 8'h0A;
   localparam logic [7:0] UNIT_SELF = 8'hFF;
   localparam logic [7:0] UNIT_MAX = 8'h20;
   localparam logic [15:0] QTY_MIN = 16'h0_001;
   localparam logic [15:0] QTY_MAX = 16'h0_07D;
   localparam logic [7:0] IDCODE_BASIC = 8'h01;
   localparam logic [7:0] IDCODE_INDIV = 8'h04;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 40000000;
   localparam int BTN_HOLD_S = 10;
   localparam longint BTN_HOLD_CYC = longint'(BTN_HOLD_S) * longint'(CLK_HZ) + 1;
   localparam int ATTEMPT_US = 1000;
   localparam int ATTEMPT_CYC = (ATTEMPT_US * (CLK_HZ / 1000000));
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {MODE_DHCP = 2'h0, MODE_BOOTP = 2'h1, MODE_FIXED = 2'h2, MODE_FALLBACK = 2'h3} mode_t;
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001, ST_DHCP = 5'b00010, ST_BOOTP = 5'b00100, ST_DONE = 5'b01000, ST_ERR = 5'b10000
   } cfg_state_t;
endpackage

//--- modbus_tcp_request_dispatcher.sv
// Request dispatcher: network setup sequencing and Modbus request screening behind APB
// Assumes APB master on pclk; stack reports lease results as same-clock pulses
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module modbus_tcp_request_dispatcher #(
   parameter longint BTN_CYC = dispatch_pkg::BTN_HOLD_CYC,
   parameter int TRY_CYC = dispatch_pkg::ATTEMPT_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Front panel button, from a pin
   input wire logic button,
   // Network stack
   input wire logic [15:0] session_port,
   input wire logic session_open,
   output logic session_accept,
   output logic dhcp_req,
   output logic bootp_req,
   input wire logic lease_ok,
   input wire logic lease_fail,
   input wire logic [31:0] lease_ip,
   output logic net_error,
   output logic net_ready,
   // Dispatch
   output logic [5:0] relay_sel,
   output logic self_sel,
   output logic req_valid
);
   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   wire logic wr_en = psel && penable && pwrite;
   wire logic rd_cyc = psel && !pwrite;
   wire logic hit_ctrl = paddr == dispatch_pkg::OFS_CTRL;
   wire logic hit_status = paddr == dispatch_pkg::OFS_STATUS;
   wire logic hit_ip_hi = paddr == dispatch_pkg::OFS_IP_HI;
   wire logic hit_ip_lo = paddr == dispatch_pkg::OFS_IP_LO;
   wire logic hit_mask = paddr == dispatch_pkg::OFS_MASK;
   wire logic hit_gw = paddr == dispatch_pkg::OFS_GW;
   wire logic hit_req = paddr == dispatch_pkg::OFS_REQ;
   wire logic hit_resp = paddr == dispatch_pkg::OFS_RESP;
   wire logic hit_aip = paddr == dispatch_pkg::OFS_ACT_IP;
   wire logic hit_amask = paddr == dispatch_pkg::OFS_ACT_MASK;
   wire logic hit_agw = paddr == dispatch_pkg::OFS_ACT_GW;
   wire logic hit_mac = paddr == dispatch_pkg::OFS_MAC;
   wire logic hit_relays = paddr == dispatch_pkg::OFS_RELAYS;
   wire logic hit_any = hit_ctrl || hit_status || hit_ip_hi || hit_ip_lo || hit_mask || hit_gw || hit_req
      || hit_resp || hit_aip || hit_amask || hit_agw || hit_mac || hit_relays;

   // ------------------------------------------------------------
   // Settings registers
   // ------------------------------------------------------------
   dispatch_pkg::mode_t mode_reg;
   logic [15:0] ip_hi_reg;
   logic [15:0] ip_lo_reg;
   logic [31:0] mask_reg;
   logic [31:0] gw_reg;
   logic [47:0] mac_reg;
   logic [5:0] relays_reg;
   logic start_reg;
   logic [31:0] req_reg;
   logic [15:0] qty_reg;
   logic [31:0] resp_reg;
   logic restore_reg;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_reg <= dispatch_pkg::MODE_FIXED;
         ip_hi_reg <= dispatch_pkg::ZERO16;
         ip_lo_reg <= dispatch_pkg::ZERO16;
         mask_reg <= 32'h0000_0000;
         gw_reg <= 32'h0000_0000;
         mac_reg <= dispatch_pkg::MAC_DEFAULT;
         relays_reg <= 6'h20;
         start_reg <= 1'b0;
         req_reg <= 32'h0000_0000;
         qty_reg <= 16'h0000;
      end
      else
      begin
         start_reg <= wr_en && hit_ctrl && pwdata[2];
         if (restore_reg)
         begin
            mode_reg <= dispatch_pkg::MODE_FIXED;
            ip_hi_reg <= dispatch_pkg::ZERO16;
            ip_lo_reg <= dispatch_pkg::ZERO16;
            mask_reg <= 32'h0000_0000;
            gw_reg <= 32'h0000_0000;
         end
         else if (wr_en && hit_ctrl)
            mode_reg <= dispatch_pkg::mode_t'(pwdata[1:0]);
         else if (wr_en && hit_ip_hi)
            ip_hi_reg <= pwdata[15:0];
         else if (wr_en && hit_ip_lo)
            ip_lo_reg <= pwdata[15:0];
         else if (wr_en && hit_mask)
            mask_reg <= pwdata;
         else if (wr_en && hit_gw)
            gw_reg <= pwdata;
         if (wr_en && hit_mac)
            mac_reg <= {mac_reg[47:32], pwdata};
         if (wr_en && hit_relays)
            relays_reg <= pwdata[5:0];
         if (wr_en && hit_req)
            req_reg <= pwdata;
         if (wr_en && hit_resp)
            qty_reg <= pwdata[15:0];
      end
   end

   // ------------------------------------------------------------
   // Button hold and restore on restart
   // ------------------------------------------------------------
   logic btn_s1_reg;
   logic btn_s2_reg;
   logic [31:0] btn_cnt_reg;
   logic armed_reg;
   wire logic held_long = btn_cnt_reg >= 32'(BTN_CYC);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         btn_s1_reg <= 1'b0;
         btn_s2_reg <= 1'b0;
         btn_cnt_reg <= 32'h0000_0000;
         armed_reg <= 1'b0;
         restore_reg <= 1'b0;
      end
      else
      begin
         btn_s1_reg <= button;
         btn_s2_reg <= btn_s1_reg;
         btn_cnt_reg <= !btn_s2_reg ? 32'h0000_0000 : (held_long ? btn_cnt_reg : btn_cnt_reg + 32'h0000_0001);
         restore_reg <= armed_reg && start_reg;
         if (restore_reg)
            armed_reg <= 1'b0;
         if (held_long)
            armed_reg <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Effective fixed settings
   // ------------------------------------------------------------
   wire logic ip_zero = (ip_hi_reg == dispatch_pkg::ZERO16) && (ip_lo_reg == dispatch_pkg::ZERO16);
   wire logic [31:0] def_ip = {dispatch_pkg::DEF_NET, mac_reg[7:0]};
   wire logic [31:0] fix_ip = ip_zero ? def_ip : {ip_hi_reg, ip_lo_reg};
   wire logic [31:0] fix_mask = (mask_reg == 32'h0000_0000) ? dispatch_pkg::DEF_MASK : mask_reg;
   wire logic [31:0] fix_gw = (gw_reg == 32'h0000_0000) ? dispatch_pkg::DEF_GW : gw_reg;

   // ------------------------------------------------------------
   // Address assignment sequencer
   // ------------------------------------------------------------
   dispatch_pkg::cfg_state_t st_reg;
   dispatch_pkg::cfg_state_t st_next;
   logic [31:0] try_cnt_reg;
   logic [31:0] act_ip_reg;
   logic [31:0] act_mask_reg;
   logic [31:0] act_gw_reg;
   wire logic timeout = try_cnt_reg >= 32'(TRY_CYC);
   wire logic try_fail = lease_fail || timeout;
   always_comb
   begin
      st_next = st_reg;
      case (st_reg)
         dispatch_pkg::ST_IDLE:
            if (start_reg)
               case (mode_reg)
                  dispatch_pkg::MODE_DHCP, dispatch_pkg::MODE_FALLBACK: st_next = dispatch_pkg::ST_DHCP;
                  dispatch_pkg::MODE_BOOTP: st_next = dispatch_pkg::ST_BOOTP;
                  default: st_next = dispatch_pkg::ST_DONE;
               endcase
         dispatch_pkg::ST_DHCP:
            if (lease_ok)
               st_next = dispatch_pkg::ST_DONE;
            else if (try_fail)
               st_next = (mode_reg == dispatch_pkg::MODE_FALLBACK) ? dispatch_pkg::ST_BOOTP
                  : dispatch_pkg::ST_ERR;
         dispatch_pkg::ST_BOOTP:
            if (lease_ok)
               st_next = dispatch_pkg::ST_DONE;
            else if (try_fail)
               st_next = (mode_reg == dispatch_pkg::MODE_FALLBACK) ? dispatch_pkg::ST_DONE
                  : dispatch_pkg::ST_ERR;
         default:
            if (start_reg)
               st_next = dispatch_pkg::ST_IDLE;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_reg <= dispatch_pkg::ST_IDLE;
         try_cnt_reg <= 32'h0000_0000;
         act_ip_reg <= 32'h0000_0000;
         act_mask_reg <= 32'h0000_0000;
         act_gw_reg <= 32'h0000_0000;
      end
      else
      begin
         st_reg <= st_next;
         try_cnt_reg <= (st_next != st_reg) ? 32'h0000_0000 : try_cnt_reg + 32'h0000_0001;
         if (st_next == dispatch_pkg::ST_DONE && st_reg != dispatch_pkg::ST_DONE)
         begin
            act_ip_reg <= lease_ok ? lease_ip : fix_ip;
            act_mask_reg <= fix_mask;
            act_gw_reg <= fix_gw;
         end
      end
   end
   assign dhcp_req = st_reg == dispatch_pkg::ST_DHCP;
   assign bootp_req = st_reg == dispatch_pkg::ST_BOOTP;
   assign net_error = st_reg == dispatch_pkg::ST_ERR;
   assign net_ready = st_reg == dispatch_pkg::ST_DONE;
   assign session_accept = net_ready && session_open && (session_port == dispatch_pkg::TCP_PORT);

   // ------------------------------------------------------------
   // Request screening: REQ word = {unit, fc, spare, idcode}
   // ------------------------------------------------------------
   wire logic [7:0] unit = req_reg[31:24];
   wire logic [7:0] fcode = req_reg[23:16];
   wire logic [7:0] idcode = req_reg[7:0];
   wire logic is_self = unit == dispatch_pkg::UNIT_SELF;
   wire logic is_relay = (unit != 8'h00) && (unit <= dispatch_pkg::UNIT_MAX) && (unit <= {2'b00, relays_reg});
   wire logic is_read = (fcode == dispatch_pkg::FC_RD_HOLD) || (fcode == dispatch_pkg::FC_RD_INPUT);
   wire logic is_write = (fcode == dispatch_pkg::FC_WR_SINGLE) || (fcode == dispatch_pkg::FC_WR_MULTI);
   wire logic is_devid = fcode == dispatch_pkg::FC_DEV_ID;
   wire logic id_ok = (idcode >= dispatch_pkg::IDCODE_BASIC) && (idcode <= dispatch_pkg::IDCODE_INDIV);
   wire logic [15:0] qty_cur = (wr_en && hit_resp) ? pwdata[15:0] : qty_reg;
   wire logic qty_ok = (qty_cur >= dispatch_pkg::QTY_MIN) && (qty_cur <= dispatch_pkg::QTY_MAX);
   wire logic fc_ok = is_read || is_write || is_devid;
   wire logic unit_ok = is_self || is_relay;
   wire logic val_ok = (!is_read || qty_ok) && (!is_devid || id_ok);
   wire logic accept = fc_ok && unit_ok && val_ok;
   wire logic [7:0] exc_code = !fc_ok ? dispatch_pkg::EXC_ILLEGAL_FC
      : (!unit_ok ? dispatch_pkg::EXC_GW_PATH : dispatch_pkg::EXC_ILLEGAL_VAL);
   wire logic [7:0] byte_cnt = {qty_cur[6:0], 1'b0};
   wire logic [7:0] info = is_devid ? dispatch_pkg::CONFORMITY : (is_read ? byte_cnt : 8'h00);
   wire logic [31:0] resp_next = accept ? {unit, fcode, info, 8'h00}
      : {unit, fcode | dispatch_pkg::EXC_BIT, exc_code, 8'h00};
   logic valid_reg;
   logic [5:0] relay_reg;
   logic self_reg;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         resp_reg <= 32'h0000_0000;
         valid_reg <= 1'b0;
         relay_reg <= 6'h00;
         self_reg <= 1'b0;
      end
      else
      begin
         valid_reg <= 1'b0;
         if (wr_en && hit_resp)
         begin
            resp_reg <= resp_next;
            valid_reg <= accept;
            relay_reg <= (accept && is_relay) ? unit[5:0] : 6'h00;
            self_reg <= accept && is_self;
         end
      end
   end
   assign req_valid = valid_reg;
   assign relay_sel = relay_reg;
   assign self_sel = self_reg;

   // ------------------------------------------------------------
   // APB read mux
   // ------------------------------------------------------------
   wire logic [31:0] status_word = {24'h00_0000, 2'b00, armed_reg, btn_s2_reg, net_error, net_ready,
      bootp_req, dhcp_req};
   wire logic [31:0] rd_mux = hit_ctrl ? {30'h0000_0000, mode_reg}
      : hit_status ? status_word
      : hit_ip_hi ? {16'h0000, ip_hi_reg}
      : hit_ip_lo ? {16'h0000, ip_lo_reg}
      : hit_mask ? mask_reg
      : hit_gw ? gw_reg
      : hit_req ? req_reg
      : hit_resp ? resp_reg
      : hit_aip ? act_ip_reg
      : hit_amask ? act_mask_reg
      : hit_agw ? act_gw_reg
      : hit_mac ? mac_reg[31:0]
      : hit_relays ? {26'h000_0000, relays_reg}
      : 32'h0000_0000;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (rd_cyc && !penable)
         prdata <= rd_mux;
   end
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit_any;
endmodule // modbus_tcp_request_dispatcher
`default_nettype wire

//--- net_peer.sv
// Model of the address servers behind the network stack
// Testbench picks each server's answer (0 silent, 1 grant, 2 refuse) and one delay shared by both
`timescale 1ns/1ps
`default_nettype none
module net_peer #(
   parameter logic [31:0] LEASE = 32'h0A00_0042
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Behaviour
   input wire logic [1:0] dhcp_ans,
   input wire logic [1:0] bootp_ans,
   input wire logic [3:0] delay,
   // Stack side
   input wire logic dhcp_req,
   input wire logic bootp_req,
   output logic lease_ok,
   output logic lease_fail,
   output logic [31:0] lease_ip
);
   logic [3:0] cnt_reg;
   logic done_reg;
   logic kind_reg;
   wire req = dhcp_req || bootp_req;
   wire [1:0] ans = dhcp_req ? dhcp_ans : bootp_ans;
   wire fire = req && !done_reg && cnt_reg == delay;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         cnt_reg <= 4'h0;
         done_reg <= 1'b0;
         kind_reg <= 1'b0;
         lease_ok <= 1'b0;
         lease_fail <= 1'b0;
         lease_ip <= 32'h0000_0000;
      end
      else
      begin
         cnt_reg <= (req && !done_reg) ? cnt_reg + 4'h1 : 4'h0;
         done_reg <= fire || (done_reg && req && dhcp_req == kind_reg);
         kind_reg <= dhcp_req;
         lease_ok <= fire && ans == 2'h1;
         lease_fail <= fire && ans == 2'h2;
         lease_ip <= (fire && ans == 2'h1) ? LEASE : ~lease_ip;
      end
endmodule // net_peer
`default_nettype wire

//--- tb_modbus_tcp_request_dispatcher.sv
// Self-checking bench: APB driver, server model, screening tables
// Assumes dispatch_pkg, the dispatcher, its checker and net_peer compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_modbus_tcp_request_dispatcher;
   localparam logic [31:0] LEASE = 32'h0A00_0042;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, button = 0, session_open = 0, slv;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, rd, rnd = 32'h0000_0007;
   logic [15:0] session_port = 16'h0000;
   logic [1:0] dhcp_ans = 2'h0, bootp_ans = 2'h0;
   logic [3:0] delay = 4'h0;
   logic [5:0] relays = 6'h20;
   wire logic [31:0] prdata, lease_ip;
   wire logic [5:0] relay_sel;
   wire logic pready, pslverr, session_accept, dhcp_req, bootp_req, lease_ok, lease_fail;
   wire logic net_error, net_ready, self_sel, req_valid;
   int errors = 0, comparisons = 0, cycles = 0, pulses = 0;
   logic [7:0] fcs [6] = '{8'h03, 8'h04, 8'h06, 8'h10, 8'h2B, 8'h07};
   logic [7:0] units [5] = '{8'hFF, 8'h01, 8'h20, 8'h21, 8'h00};
   modbus_tcp_request_dispatcher #(.BTN_CYC(20), .TRY_CYC(10)) modbus_tcp_request_dispatcher_i (.*);
   net_peer #(.LEASE(LEASE)) net_peer_i (.*);
   initial forever #12.5 pclk = ~pclk;
   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (req_valid === 1'b1) pulses <= pulses + 1;
      if (cycles == 20000)
      begin
         errors = errors + 1;
         print_verdict();
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [31:0] exp_resp(input logic [7:0] u, f, d, input logic [15:0] q, input logic [5:0] n);
      logic [7:0] e;
      logic [7:0] info;
      e = 8'h00;
      info = (f == 8'h2B) ? 8'h82 : (f == 8'h03 || f == 8'h04) ? {q[6:0], 1'b0} : 8'h00;
      if (!(f inside {8'h03, 8'h04, 8'h06, 8'h10, 8'h2B})) e = 8'h01;
      else if (u != 8'hFF && (u == 8'h00 || u > {2'b00, n})) e = 8'h0A;
      else if ((f == 8'h03 || f == 8'h04) && (q == 16'h0000 || q > 16'h007D)) e = 8'h03;
      else if (f == 8'h2B && (d == 8'h00 || d > 8'h04)) e = 8'h03;
      return (e != 8'h00) ? {u, f | 8'h80, e, 8'h00} : {u, f, info, 8'h00};
   endfunction
   task automatic check(input string n, input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic run_cfg(input logic [1:0] m, input logic ok, input logic [31:0] ip);
      int n;
      if (net_ready === 1'b1 || net_error === 1'b1) apb(1'b1, 12'h000, {29'h0, 1'b1, m}, rd);
      apb(1'b1, 12'h000, {29'h0, 1'b1, m}, rd);
      n = 0;
      while (net_ready !== 1'b1 && net_error !== 1'b1 && n < 200)
      begin
         @(posedge pclk);
         n++;
      end
      check("ready", {net_error, net_ready}, {~ok, ok});
      apb(1'b0, 12'h020, 32'h0000_0000, rd);
      if (ok) check("act_ip", rd, ip);
   endtask
   task automatic try_cfg(input logic [1:0] m, da, ba, input logic [3:0] dl, input logic ok, input logic [31:0] ip);
      dhcp_ans <= da;
      bootp_ans <= ba;
      delay <= dl;
      run_cfg(m, ok, ip);
   endtask
   task automatic screen(input logic [7:0] u, f, d, input logic [15:0] q);
      logic [31:0] e;
      int p;
      e = exp_resp(u, f, d, q, relays);
      p = pulses;
      apb(1'b1, 12'h018, {u, f, 8'h00, d}, rd);
      apb(1'b1, 12'h01C, {16'h0000, q}, rd);
      apb(1'b0, 12'h01C, 32'h0000_0000, rd);
      check("resp", rd, e);
      check("self", self_sel, !e[23] && u == 8'hFF);
      check("relay", relay_sel, (!e[23] && u != 8'hFF) ? u[5:0] : 6'h00);
      check("valid", 32'(pulses - p), {31'h0, !e[23]});
   endtask
   task automatic print_verdict();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0000_0000, rd);
      check("mode", rd[1:0], 2'h2);
      apb(1'b0, 12'h030, 32'h0000_0000, rd);
      check("relays", rd, 32'h0000_0020);
      apb(1'b0, 12'h040, 32'h0000_0000, rd);
      check("unmapped", {rd, slv}, 33'h0_0000_0001);
      $display("reset test done");
      run_cfg(2'h2, 1'b1, 32'hC0A8_0101);
      apb(1'b0, 12'h024, 32'h0000_0000, rd);
      check("mask", rd, 32'hFFFF_FF00);
      apb(1'b0, 12'h028, 32'h0000_0000, rd);
      check("gw", rd, 32'hC0A8_01FE);
      session_open <= 1'b1;
      foreach (fcs[i])
      begin
         session_port <= 16'h01F5 + 16'(i % 3);
         @(posedge pclk);
         check("accept", session_accept, i % 3 == 1);
      end
      rnd = xs(rnd);
      apb(1'b1, 12'h008, 32'h0000_C0A8, rd);
      apb(1'b1, 12'h00C, 32'h0000_0164, rd);
      apb(1'b1, 12'h010, rnd | 32'h0000_0001, rd);
      run_cfg(2'h2, 1'b1, 32'hC0A8_0164);
      apb(1'b0, 12'h024, 32'h0000_0000, rd);
      check("fixed_mask", rd, rnd | 32'h0000_0001);
      $display("fixed test done");
      try_cfg(2'h0, 2'h1, 2'h0, 4'h0, 1'b1, LEASE);
      try_cfg(2'h0, 2'h1, 2'h0, 4'h6, 1'b1, LEASE);
      try_cfg(2'h0, 2'h0, 2'h0, 4'h0, 1'b0, LEASE);
      try_cfg(2'h1, 2'h0, 2'h2, 4'h2, 1'b0, LEASE);
      try_cfg(2'h1, 2'h0, 2'h1, 4'h5, 1'b1, LEASE);
      try_cfg(2'h3, 2'h2, 2'h1, 4'h1, 1'b1, LEASE);
      try_cfg(2'h3, 2'h0, 2'h2, 4'h3, 1'b1, 32'hC0A8_0164);
      $display("lease test done");
      foreach (fcs[i])
         foreach (units[j])
         begin
            rnd = xs(rnd);
            screen(units[j], fcs[i], 8'(j), 16'(rnd % 123 + 1));
         end
      screen(8'hFF, 8'h03, 8'h01, 16'h0000);
      screen(8'hFF, 8'h04, 8'h01, 16'h007E);
      screen(8'h01, 8'h03, 8'h01, 16'h007D);
      apb(1'b1, 12'h030, 32'h0000_0004, rd);
      relays = 6'h04;
      screen(8'h05, 8'h03, 8'h01, 16'h0001);
      screen(8'h04, 8'h06, 8'h01, 16'h0003);
      $display("screen test done");
      button <= 1'b1;
      repeat (30) @(posedge pclk);
      button <= 1'b0;
      apb(1'b1, 12'h000, 32'h0000_0004, rd);
      repeat (2) @(posedge pclk);
      apb(1'b0, 12'h000, 32'h0000_0000, rd);
      check("restored_mode", rd[1:0], 2'h2);
      run_cfg(2'h2, 1'b1, 32'hC0A8_0101);
      $display("restore test done");
      print_verdict();
   end
endmodule // tb_modbus_tcp_request_dispatcher
bind modbus_tcp_request_dispatcher dispatch_checker #(.TRY_CYC(TRY_CYC)) dispatch_checker_i (.*);
`default_nettype wire
